// >>> adc_sample_packetizer.sv
// converter control, register file and sample packet engine
`timescale 1ns/1ps
module adc_sample_packetizer (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        sample_trig,
  input  wire logic [11:0] adc_result,
  output logic      [1:0]  adc_sel,
  output logic             adc_cal,
  output logic             pkt_valid,
  input  wire logic        pkt_ready,
  output logic      [7:0]  pkt_data,
  output logic             pkt_end,
  output logic      [23:0] pkt_dest
);
  typedef enum logic [1:0] {EM_IDLE, EM_DATA, EM_END} em_state_t;

  // ==========================================================
  // registers
  logic [23:0] dest_ff [4];
  logic [23:0] nxt_dest [4];
  logic [3:0]  pin_en_ff, nxt_pin_en;
  logic        gen_en_ff, nxt_gen_en;
  logic        cal_ff, nxt_cal;
  logic [7:0]  spp_ff, nxt_spp;
  logic [1:0]  wid_ff, nxt_wid;
  logic        drop_ff, nxt_drop;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        hit, gen_hit, drop_evt;
  logic [3:0]  pin_hit;

  always_comb begin
    pin_hit[0] = 1'b0;
    pin_hit[1] = 1'b0;
    pin_hit[2] = 1'b0;
    pin_hit[3] = 1'b0;
    if (reg_addr == adc_pkt_pkg::OFS_PIN0) begin
      pin_hit[0] = 1'b1;
    end else if (reg_addr == adc_pkt_pkg::OFS_PIN1) begin
      pin_hit[1] = 1'b1;
    end else if (reg_addr == adc_pkt_pkg::OFS_PIN2) begin
      pin_hit[2] = 1'b1;
    end else if (reg_addr == adc_pkt_pkg::OFS_PIN3) begin
      pin_hit[3] = 1'b1;
    end
    gen_hit = (reg_addr == adc_pkt_pkg::OFS_GEN);
    hit     = (|pin_hit || gen_hit) && (reg_wr || reg_rd);
  end

  always_comb begin
    nxt_dest   = dest_ff;
    nxt_pin_en = pin_en_ff;
    nxt_gen_en = gen_en_ff;
    nxt_cal    = cal_ff;
    nxt_spp    = spp_ff;
    nxt_wid    = wid_ff;
    nxt_drop   = drop_ff;
    nxt_rdata  = rdata_ff;
    for (int i = 0; i < adc_pkt_pkg::NUM_PINS; i++) begin
      if (reg_wr && pin_hit[i] && !gen_en_ff) begin
        nxt_dest[i]   = reg_wdata[31:adc_pkt_pkg::PIN_DEST_LSB];
        nxt_pin_en[i] = reg_wdata[adc_pkt_pkg::PIN_EN_BIT];
      end
      if (reg_rd && pin_hit[i]) begin
        nxt_rdata = {dest_ff[i], 7'h00, pin_en_ff[i]};
      end
    end
    if (reg_wr && gen_hit) begin
      nxt_gen_en = reg_wdata[adc_pkt_pkg::GEN_EN_BIT];
      nxt_cal    = reg_wdata[adc_pkt_pkg::GEN_CAL_BIT];
      nxt_spp    = reg_wdata[adc_pkt_pkg::GEN_SPP_LSB +: 8];
      nxt_wid    = reg_wdata[adc_pkt_pkg::GEN_WID_LSB +: 2];
    end
    if (reg_rd && gen_hit) begin
      nxt_rdata = {7'h00, drop_ff, 6'h00, wid_ff, spp_ff, 6'h00, cal_ff, gen_en_ff};
      nxt_drop  = 1'b0;
    end
    if (reg_rd && !(|pin_hit) && !gen_hit) begin
      nxt_rdata = 32'h00000000;
    end
    // a drop in the read cycle wins
    if (drop_evt) begin
      nxt_drop = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < adc_pkt_pkg::NUM_PINS; i++) begin
        dest_ff[i] <= 24'h000000;
      end
      pin_en_ff <= 4'h0;
      gen_en_ff <= 1'b0;
      cal_ff    <= 1'b0;
      // one sample per packet after reset
      spp_ff    <= adc_pkt_pkg::SPP_RESET;
      wid_ff    <= adc_pkt_pkg::WID_RESET;
      drop_ff   <= adc_pkt_pkg::DROP_RESET;
      rdata_ff  <= 32'h00000000;
    end else begin
      dest_ff   <= nxt_dest;
      pin_en_ff <= nxt_pin_en;
      gen_en_ff <= nxt_gen_en;
      cal_ff    <= nxt_cal;
      spp_ff    <= nxt_spp;
      wid_ff    <= nxt_wid;
      drop_ff   <= nxt_drop;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign adc_cal   = cal_ff;

  // ==========================================================
  // sampling and packet engine
  em_state_t   state_ff, nxt_state;
  logic        trig_d_ff, trig_rise;
  logic [1:0]  sel_ff, nxt_sel, em_pin_ff, nxt_em_pin;
  logic [2:0]  warm_ff, nxt_warm;
  logic [31:0] shr_ff, nxt_shr;
  logic [2:0]  left_ff, nxt_left;
  logic        close_ff, nxt_close;
  logic [3:0]  open_ff, nxt_open, pend_ff, nxt_pend;
  logic [7:0]  cnt_ff [4];
  logic [7:0]  nxt_cnt [4];
  logic [31:0] fmt_word;
  logic [2:0]  fmt_bytes;
  logic [1:0]  after_sel, end_pin;
  logic        take, end_any;

  sample_formatter u_fmt (
    .sample     (adc_result),
    .width_code (wid_ff),
    .word       (fmt_word),
    .nbytes     (fmt_bytes)
  );

  // next enabled pin after sel_ff, wrapping
  always_comb begin
    after_sel = sel_ff;
    for (int i = 3; i >= 1; i--) begin
      if (pin_en_ff[sel_ff + 2'(i)]) begin
        after_sel = sel_ff + 2'(i);
      end
    end
    end_pin = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (pend_ff[i] && open_ff[i]) begin
        end_pin = 2'(i);
      end
    end
  end

  always_comb begin
    trig_rise  = sample_trig && !trig_d_ff;
    // only pulses after warm-up carry samples
    take       = trig_rise && gen_en_ff && (warm_ff == adc_pkt_pkg::WARMUP_PULSES) && pin_en_ff[sel_ff];
    drop_evt   = take && (state_ff != EM_IDLE);
    end_any    = |(pend_ff & open_ff);
    nxt_state  = state_ff;
    nxt_sel    = sel_ff;
    nxt_em_pin = em_pin_ff;
    nxt_warm   = warm_ff;
    nxt_shr    = shr_ff;
    nxt_left   = left_ff;
    nxt_close  = close_ff;
    nxt_open   = open_ff;
    nxt_pend   = pend_ff;
    nxt_cnt    = cnt_ff;
    if (!gen_en_ff) begin
      nxt_warm = 3'h0;
    end else if (trig_rise && warm_ff != adc_pkt_pkg::WARMUP_PULSES) begin
      nxt_warm = warm_ff + 3'h1;
    end
    // keep the selector on an enabled pin between triggers
    if (!pin_en_ff[sel_ff] || (trig_rise && gen_en_ff && warm_ff == adc_pkt_pkg::WARMUP_PULSES)) begin
      // advance to the next pin in turn
      nxt_sel = after_sel;
    end
    // with no count, any access to a pin or general register closes open packets
    if (hit && spp_ff == 8'h00) begin
      nxt_pend = open_ff;
    end
    case (state_ff)
      EM_IDLE: begin
        if (take) begin
          nxt_state  = EM_DATA;
          nxt_em_pin = sel_ff;
          nxt_shr    = fmt_word;
          nxt_left   = fmt_bytes;
          nxt_open[sel_ff] = 1'b1;
          // close when the count is reached
          nxt_close  = (spp_ff != 8'h00) && (cnt_ff[sel_ff] + 8'h01 == spp_ff);
          nxt_cnt[sel_ff] = nxt_close ? 8'h00 : cnt_ff[sel_ff] + 8'h01;
        end else if (end_any) begin
          nxt_state  = EM_END;
          nxt_em_pin = end_pin;
        end
      end
      EM_DATA: begin
        if (pkt_ready) begin
          // shift toward the next lower byte
          nxt_shr  = {shr_ff[23:0], 8'h00};
          nxt_left = left_ff - 3'h1;
          if (left_ff == 3'h1) begin
            nxt_state = close_ff ? EM_END : EM_IDLE;
          end
        end
      end
      EM_END: begin
        if (pkt_ready) begin
          nxt_state            = EM_IDLE;
          nxt_open[em_pin_ff]  = 1'b0;
          nxt_pend[em_pin_ff]  = 1'b0;
          nxt_cnt[em_pin_ff]   = 8'h00;
        end
      end
      default: nxt_state = EM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff  <= EM_IDLE;
      trig_d_ff <= 1'b0;
      sel_ff    <= 2'h0;
      em_pin_ff <= 2'h0;
      warm_ff   <= 3'h0;
      shr_ff    <= 32'h00000000;
      left_ff   <= 3'h0;
      close_ff  <= 1'b0;
      open_ff   <= 4'h0;
      pend_ff   <= 4'h0;
      for (int i = 0; i < adc_pkt_pkg::NUM_PINS; i++) begin
        cnt_ff[i] <= 8'h00;
      end
    end else begin
      state_ff  <= nxt_state;
      trig_d_ff <= sample_trig;
      sel_ff    <= nxt_sel;
      em_pin_ff <= nxt_em_pin;
      warm_ff   <= nxt_warm;
      shr_ff    <= nxt_shr;
      left_ff   <= nxt_left;
      close_ff  <= nxt_close;
      open_ff   <= nxt_open;
      pend_ff   <= nxt_pend;
      cnt_ff    <= nxt_cnt;
    end
  end

  assign adc_sel   = sel_ff;
  assign pkt_valid = (state_ff != EM_IDLE);
  assign pkt_end   = (state_ff == EM_END);
  assign pkt_data  = shr_ff[31:24];
  // packets go to the pin's destination
  assign pkt_dest  = dest_ff[em_pin_ff];

  // ==========================================================
  // checks
  sequence seq_last_byte;
    (state_ff == EM_DATA) && pkt_ready && (left_ff == 3'h1) && close_ff;
  endsequence
  sequence seq_end_token;
    pkt_valid && pkt_end;
  endsequence

  a_drop_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (take && state_ff != EM_IDLE) |=> drop_ff) else $error("dropped sample not flagged");
  a_read_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && gen_hit && !drop_evt) |=> !drop_ff && reg_rdata[24] == $past(drop_ff))
    else $error("drop flag read or clear wrong");
  a_pin_lock: assert property (@(posedge core_clk) disable iff (sys_rst)
    (gen_en_ff && reg_wr && pin_hit[0]) |=> $stable(dest_ff[0]) && $stable(pin_en_ff[0]))
    else $error("pin register changed while enabled");
  a_warmup_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    (trig_rise && gen_en_ff && warm_ff < 3'h6) |=> warm_ff == $past(warm_ff) + 3'h1 && state_ff == EM_IDLE)
    else $error("warm-up pulse produced data");
  a_msb_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((state_ff == EM_DATA) && pkt_ready && left_ff > 3'h1) |=> pkt_data == $past(shr_ff[23:16]))
    else $error("byte order wrong");
  a_close_end: assert property (@(posedge core_clk) disable iff (sys_rst)
    seq_last_byte |=> seq_end_token) else $error("packet not closed at count");
  a_hold_open: assert property (@(posedge core_clk) disable iff (sys_rst)
    (spp_ff == 8'h00 && pend_ff == 4'h0 && !hit) |=> !(pkt_valid && pkt_end && $past(state_ff) == EM_IDLE))
    else $error("packet closed without access");
  a_pin_enabled: assert property (@(posedge core_clk) disable iff (sys_rst)
    (take && state_ff == EM_IDLE) |-> pin_en_ff[sel_ff] ##1 (state_ff == EM_DATA) [*1] ##0 pin_en_ff[em_pin_ff])
    else $error("disabled pin sampled");
  a_cal_switch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && gen_hit) |=> adc_cal == $past(reg_wdata[1])) else $error("calibration select wrong");
endmodule

// >>> adc_pkt_pkg.sv
// constants shared by the converter packetizer files
package adc_pkt_pkg;
  localparam int          NUM_PINS      = 4;
  localparam int          SAMPLE_W      = 12;
  localparam int          DEST_W        = 24;
  // register byte offsets
  localparam logic [7:0]  OFS_PIN0      = 8'h00;
  localparam logic [7:0]  OFS_PIN1      = 8'h04;
  localparam logic [7:0]  OFS_PIN2      = 8'h08;
  localparam logic [7:0]  OFS_PIN3      = 8'h0c;
  localparam logic [7:0]  OFS_GEN       = 8'h20;
  // per-pin control fields
  localparam int          PIN_EN_BIT    = 0;
  localparam int          PIN_DEST_LSB  = 8;
  // general control fields
  localparam int          GEN_EN_BIT    = 0;
  localparam int          GEN_CAL_BIT   = 1;
  localparam int          GEN_SPP_LSB   = 8;
  localparam int          GEN_WID_LSB   = 16;
  localparam int          GEN_DROP_BIT  = 24;
  // reset values
  localparam logic [1:0]  WID_RESET     = 2'h1;
  localparam logic [7:0]  SPP_RESET     = 8'h01;
  localparam logic        DROP_RESET    = 1'b1;
  // width codes
  localparam logic [1:0]  WID_8         = 2'h0;
  localparam logic [1:0]  WID_16        = 2'h1;
  localparam logic [1:0]  WID_32        = 2'h3;
  // trigger pulses spent on warm-up after enabling
  localparam logic [2:0]  WARMUP_PULSES = 3'h6;
endpackage

// >>> sample_formatter.sv
// left-aligns a converter result to the selected sample width
`timescale 1ns/1ps
module sample_formatter (
  input  wire logic [11:0] sample,
  input  wire logic [1:0]  width_code,
  output logic      [31:0] word,
  output logic      [2:0]  nbytes
);
  // msb-first: byte 0 of the stream is word[31:24]
  always_comb begin
    word   = {sample, 20'h00000};
    nbytes = 3'h2;
    if (width_code == adc_pkt_pkg::WID_8) begin
      word   = {sample[11:4], 24'h000000};
      nbytes = 3'h1;
    end else if (width_code == adc_pkt_pkg::WID_32) begin
      nbytes = 3'h4;
    end
  end
endmodule

// >>> pkt_sink.sv
// receiving channel-end model: takes tokens and logs them
`timescale 1ns/1ps
module pkt_sink (
  input  wire logic        core_clk,
  input  wire logic        slow,
  input  wire logic        hold,
  input  wire logic        pkt_valid,
  output logic             pkt_ready,
  input  wire logic [7:0]  pkt_data,
  input  wire logic        pkt_end,
  input  wire logic [23:0] pkt_dest
);
  logic [32:0] got_q[$];
  // end token data is ignored, so it is logged as zero
  always @(posedge core_clk) begin
    if (pkt_valid && pkt_ready) begin
      got_q.push_back({pkt_end, pkt_end ? 8'h00 : pkt_data, pkt_dest});
    end
    pkt_ready <= !hold && (!slow || 1'($urandom_range(1)));
  end
endmodule

// >>> tb.sv
// self-checking bench for the converter packetizer
`timescale 1ns/1ps
module tb;
  logic        core_clk    = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [7:0]  reg_addr    = 8'h00;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [31:0] reg_wdata   = 32'h0;
  logic        sample_trig = 1'b0;
  logic [11:0] adc_result  = 12'h0;
  logic        slow        = 1'b0;
  logic        hold        = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0]  adc_sel;
  logic        adc_cal;
  logic        pkt_valid;
  logic        pkt_ready;
  logic [7:0]  pkt_data;
  logic        pkt_end;
  logic [23:0] pkt_dest;
  logic [23:0] dest[4];
  logic [7:0]  cnt[4];
  logic [32:0] exp_q[$];
  logic [1:0]  wl[3] = '{2'h0, 2'h1, 2'h3};
  logic [7:0]  spp;
  int          bad_count = 0;
  int          checked   = 0;

  always #2.5 core_clk = ~core_clk;

  adc_sample_packetizer dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_trig(sample_trig),
    .adc_result(adc_result), .adc_sel(adc_sel), .adc_cal(adc_cal), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_data(pkt_data), .pkt_end(pkt_end), .pkt_dest(pkt_dest));
  pkt_sink sink_u (.core_clk(core_clk), .slow(slow), .hold(hold), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_data(pkt_data), .pkt_end(pkt_end), .pkt_dest(pkt_dest));

  // ==========================================
  // helpers
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    check(33'(reg_rdata), 33'(exp), "register read");
    tick;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (pkt_valid !== 1'b0 && n < 100) begin
      tick;
      n++;
    end
    if (pkt_valid !== 1'b0) begin
      bad_count++;
      finish_test;
    end
  endtask
  // expected bytes: left aligned, most significant first
  function automatic void expect_sample(input logic [1:0] p, input logic [11:0] s, input logic [1:0] w);
    logic [31:0] word;
    int          nb;
    word = {s, 20'h0};
    nb = (w == 2'h0) ? 1 : (w == 2'h3) ? 4 : 2;
    for (int i = 0; i < nb; i++) exp_q.push_back({1'b0, word[31-8*i -: 8], dest[p]});
    cnt[p]++;
    if (spp != 8'h00 && cnt[p] == spp) begin
      exp_q.push_back({1'b1, 8'h00, dest[p]});
      cnt[p] = 8'h00;
    end
  endfunction
  task automatic pulse(input logic [1:0] p, input logic [1:0] w, input logic live);
    adc_result = 12'($urandom);
    if (live) check(33'(adc_sel), 33'(p), "pin select");
    sample_trig = 1'b1;
    tick;
    sample_trig = 1'b0;
    tick;
    if (live) expect_sample(p, adc_result, w);
    wait_idle;
    tick;
  endtask
  task automatic compare_q;
    check(33'(sink_u.got_q.size()), 33'(exp_q.size()), "token count");
    while (exp_q.size() > 0 && sink_u.got_q.size() > 0) begin
      check(sink_u.got_q.pop_front(), exp_q.pop_front(), "token");
    end
    sink_u.got_q.delete();
    exp_q.delete();
  endtask

  initial begin
    #200000;
    bad_count++;
    finish_test;
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'heab7a79f));
    repeat (8) tick;
    sys_rst = 1'b0;
    rdchk(adc_pkt_pkg::OFS_GEN, 32'h0101_0100);
    rdchk(adc_pkt_pkg::OFS_GEN, 32'h0001_0100);
    rdchk(8'h10, 32'h0);
    for (int p = 0; p < 4; p++) begin
      rdchk(8'(4*p), 32'h0);
      dest[p] = 24'($urandom);
      cnt[p] = 8'h00;
      wr(8'(4*p), {dest[p], 7'h0, ~p[0]});
      rdchk(8'(4*p), {dest[p], 7'h0, ~p[0]});
    end
    foreach (wl[i]) begin
      spp = 8'(1 << i);
      slow = i[0];
      wr(adc_pkt_pkg::OFS_GEN, 32'h0);
      wr(adc_pkt_pkg::OFS_GEN, {14'h0, wl[i], spp, 8'h01});
      repeat (6) pulse(2'h0, wl[i], 1'b0);
      check(33'(sink_u.got_q.size()), 33'h0, "warm-up tokens");
      wr(adc_pkt_pkg::OFS_PIN1, 32'hffff_ff01);
      rdchk(adc_pkt_pkg::OFS_PIN1, {dest[1], 8'h00});
      wr(adc_pkt_pkg::OFS_PIN0, 32'h0000_0000);
      rdchk(adc_pkt_pkg::OFS_PIN0, {dest[0], 8'h01});
      for (int k = 0; k < 8; k++) pulse(2'(2*(k%2)), wl[i], 1'b1);
      compare_q;
    end
    spp = 8'h00;
    wr(adc_pkt_pkg::OFS_GEN, 32'h0);
    wr(adc_pkt_pkg::OFS_GEN, 32'h0000_0001);
    repeat (6) pulse(2'h0, 2'h0, 1'b0);
    for (int k = 0; k < 3; k++) pulse(2'(2*(k%2)), 2'h0, 1'b1);
    check(33'(sink_u.got_q.size()), 33'h3, "open packet");
    rdchk(adc_pkt_pkg::OFS_GEN, 32'h0000_0001);
    repeat (3) tick;
    wait_idle;
    exp_q.push_back({1'b1, 8'h00, dest[0]});
    exp_q.push_back({1'b1, 8'h00, dest[2]});
    compare_q;
    wr(adc_pkt_pkg::OFS_GEN, 32'h0001_0103);
    check(33'(adc_cal), 33'h1, "calibration input");
    // samples near the switch are not checked
    wr(adc_pkt_pkg::OFS_GEN, 32'h0001_0101);
    check(33'(adc_cal), 33'h0, "calibration input");
    wr(adc_pkt_pkg::OFS_GEN, 32'h0);
    wr(adc_pkt_pkg::OFS_GEN, 32'h0001_0101);
    spp = 8'h01;
    cnt[2] = 8'h00;
    hold = 1'b1;
    repeat (6) pulse(2'h0, 2'h1, 1'b0);
    // the open-packet run left the selector on pin 2
    check(33'(adc_sel), 33'h2, "pin select");
    // second rise lands while the first sample is still stalled
    repeat (2) begin
      sample_trig = 1'b1;
      tick;
      sample_trig = 1'b0;
      tick;
    end
    expect_sample(2'h2, adc_result, 2'h1);
    rdchk(adc_pkt_pkg::OFS_GEN, 32'h0101_0101);
    rdchk(adc_pkt_pkg::OFS_GEN, 32'h0001_0101);
    hold = 1'b0;
    wait_idle;
    compare_q;
    finish_test;
  end
endmodule
